// file: rtl/dte_engine.sv
// Dataflow token engine: token stores, elements, switch and register slave
// How it works
// - Element fires only when all inputs full
// - Element accesses: read, read-erase, write only
// - Result written only into empty output store
// - Write to full store stalls until empty
// - Done when no element active or fireable
// - Elements run concurrently and independently
// - Execution starts once stores are loaded
// - Stores indexed 0 to NS-1
// - Store command: init clears, set loads attributes
// - Store switch side: fill flag plus data
// - Store reports fill state and exception code
// - Elements indexed 0 to NE-1
// - Element command: opcode plus port/cost/time attributes
// - Element ports see fill flag plus data
// - Element reports active state and exception code
// - Active from consume until done processing
// - Switch routes any store to any element
// - Switch has internal, external and processing ports
// - Connector passes fill flag and data across
// - Store exception codes 00/01/10/11
// - Element exception codes 00/01/10/11
module dte_engine (
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	input  dte_pkg::dte_av_req_t av_req,
	output dte_pkg::dte_av_rsp_t av_rsp,
	input  wire logic          ext_fill,
	input  wire logic [7:0]    ext_data,
	output logic               done
);
	import dte_pkg::*;

	dte_state_t s;
	dte_state_t next_s;
	logic [NE-1:0] ina_full;
	logic [NE-1:0] fire;
	logic [NE-1:0] unary;

	assign av_rsp = s.rsp;
	assign done   = s.done;

	// --------------------------------
	// Switch connectors: store or external port to element port
	// --------------------------------
	function automatic logic sel_fill(input dte_state_t c, input logic [2:0] i);
		sel_fill = (i == EXT_SEL) ? c.ext2[DW] : (i < EXT_SEL) && c.fill[i[1:0]];
	endfunction
	function automatic logic [DW-1:0] sel_data(input dte_state_t c, input logic [2:0] i);
		sel_data = (i == EXT_SEL) ? c.ext2[DW-1:0] : c.data[i[1:0]];
	endfunction

	always_comb begin
		logic [NS-1:0] er_claim;
		logic [NS-1:0] wr_claim;
		logic [NE-1:0] act;
		logic          fire_any;
		logic [DW-1:0] va;
		logic [DW-1:0] vb;
		logic [2:0]    ia;
		logic [2:0]    ib;
		logic [1:0]    io;
		logic [NS-1:0] need;
		logic [31:0]   w;
		next_s   = s;
		er_claim = '0;
		wr_claim = '0;
		act      = '0;
		fire_any = 1'b0;
		va       = '0;
		vb       = '0;
		ia       = '0;
		ib       = '0;
		io       = '0;
		need     = '0;
		w        = av_req.writedata;
		ina_full = '0;
		fire     = '0;
		unary    = '0;
		next_s.ext1 = {ext_fill, ext_data};
		next_s.ext2 = s.ext1;
		// --------------------------------
		// Elements, each on its own state
		// --------------------------------
		for (int i = 0; i < NE; i++) begin
			ia = s.pe[i].cfg.a;
			ib = s.pe[i].cfg.b;
			io = s.pe[i].cfg.o;
			va = sel_data(s, ia);
			vb = sel_data(s, ib);
			unary[i] = (s.pe[i].cfg.op == OP_PASS) || (s.pe[i].cfg.op == OP_JUMP);
			ina_full[i] = sel_fill(s, ia) && (unary[i] || sel_fill(s, ib));
			case (s.pe[i].st)
				ST_IDLE: begin
					if (s.pe[i].cfg.en && !s.halt && s.pe[i].exc == PX_NONE
							&& ina_full[i]) begin
						fire_any = 1'b1;
						need = '0;
						if (s.pe[i].cfg.er && ia < EXT_SEL)
							need[ia[1:0]] = 1'b1;
						if (s.pe[i].cfg.er && !unary[i] && ib < EXT_SEL)
							need[ib[1:0]] = 1'b1;
						if ((need & er_claim) != '0) begin
							for (int k = 0; k < NS; k++) begin
								if (need[k] && er_claim[k])
									next_s.sexc[k] = SX_ER;
							end
						end else begin
							fire[i] = 1'b1;
							er_claim = er_claim | need;
							next_s.fill = next_s.fill & ~need;
							next_s.pe[i].st = ST_RUN;
							next_s.pe[i].cnt = s.pe[i].cfg.t;
							next_s.pe[i].exc = PX_NONE;
							case (s.pe[i].cfg.op)
								OP_PASS: next_s.pe[i].res = {1'b0, va};
								OP_ADD: begin
									next_s.pe[i].res = {1'b0, va} + {1'b0, vb};
									if (next_s.pe[i].res[DW])
										next_s.pe[i].exc = PX_OVF;
								end
								OP_SUB: begin
									next_s.pe[i].res = {1'b0, va} - {1'b0, vb};
									if (va < vb)
										next_s.pe[i].exc = PX_OVF;
								end
								OP_AND: next_s.pe[i].res = {1'b0, va & vb};
								OP_XOR: next_s.pe[i].res = {1'b0, va ^ vb};
								OP_JUMP: begin
									next_s.pe[i].res = {1'b0, va};
									next_s.pe[i].exc = PX_FLOW;
								end
								default: begin
									next_s.pe[i].res = '0;
									next_s.pe[i].exc = PX_UNDEF;
								end
							endcase
						end
					end
				end
				ST_RUN: begin
					if (s.pe[i].cnt != 4'h0)
						next_s.pe[i].cnt = s.pe[i].cnt - 4'h1;
					else if (s.pe[i].exc != PX_NONE)
						next_s.pe[i].st = ST_IDLE;
					else
						next_s.pe[i].st = ST_WR;
				end
				ST_WR: begin
					if (!s.fill[io] && !wr_claim[io]) begin
						wr_claim[io] = 1'b1;
						next_s.pe[i].st = ST_IDLE;
						if ((s.pe[i].res[DW-1:0] >> s.size[io]) != '0)
							next_s.sexc[io] = SX_SIZE;
						else begin
							next_s.fill[io] = 1'b1;
							next_s.data[io] = s.pe[i].res[DW-1:0];
						end
					end
				end
				default: next_s.pe[i].st = ST_IDLE;
			endcase
			act[i] = next_s.pe[i].st != ST_IDLE;
		end
		next_s.done = (act == '0) && !fire_any;
		// --------------------------------
		// Avalon-MM slave, one wait cycle
		// --------------------------------
		next_s.rsp.waitrequest = 1'b1;
		if ((av_req.read || av_req.write) && s.rsp.waitrequest) begin
			next_s.rsp.waitrequest = 1'b0;
			next_s.rsp.readdata = '0;
			if (av_req.write) begin
				case (av_req.address)
					A_STORE: begin
						io = w[SC_IDX +: 2];
						if (w[SC_INIT]) begin
							next_s.fill[io] = 1'b0;
							next_s.sexc[io] = SX_NONE;
							next_s.size[io] = w[SC_SIZE +: 4];
						end
						if (w[SC_LOAD]) begin
							if (next_s.fill[io])
								next_s.sexc[io] = SX_WR;
							else begin
								next_s.fill[io] = 1'b1;
								next_s.data[io] = w[SC_DATA +: DW];
							end
						end
					end
					A_PE: begin
						next_s.pe[w[PC_PE]].cfg = {w[PC_EN], w[PC_OP +: 3], w[PC_A +: 3],
							w[PC_B +: 3], w[PC_O +: 2], w[PC_ER], w[PC_T +: 4]};
						next_s.pe[w[PC_PE]].exc = PX_NONE;
						next_s.pe[w[PC_PE]].st = ST_IDLE;
					end
					A_HALT: next_s.halt = w[0];
					default: next_s.halt = s.halt;
				endcase
			end else begin
				case (av_req.address)
					A_STAT: begin
						next_s.rsp.readdata[NS-1:0] = s.fill;
						next_s.rsp.readdata[ST_SEXC +: 2*NS] = s.sexc;
						for (int i = 0; i < NE; i++) begin
							next_s.rsp.readdata[ST_ACT + i] = s.pe[i].st != ST_IDLE;
							next_s.rsp.readdata[ST_PEXC + 2*i +: 2] = s.pe[i].exc;
						end
						next_s.rsp.readdata[ST_DONE] = s.done;
					end
					A_DATA: next_s.rsp.readdata = s.data;
					A_HALT: next_s.rsp.readdata[0] = s.halt;
					default: next_s.rsp.readdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			for (int k = 0; k < NS; k++) begin
				s.size[k] <= SIZE_RST;
				s.data[k] <= DATA_RST;
			end
			for (int i = 0; i < NE; i++)
				s.pe[i].st <= ST_IDLE;
			s.rsp.waitrequest <= 1'b1;
		end else
			s <= next_s;
	end

	// --------------------------------
	// Checks
	// --------------------------------
	sequence q_fire0;
		s.pe[0].st == ST_IDLE ##1 s.pe[0].st == ST_RUN;
	endsequence
	property p_fire_full;
		@(posedge sys_clk) disable iff (!rst_n) q_fire0 |-> $past(ina_full[0]);
	endproperty
	a_fire_full: assert property (p_fire_full) else $error("fired with input empty");
	property p_wr_stall;
		@(posedge sys_clk) disable iff (!rst_n)
			s.pe[0].st == ST_WR && s.fill[s.pe[0].cfg.o] && !av_req.write
			|=> s.pe[0].st == ST_WR;
	endproperty
	a_wr_stall: assert property (p_wr_stall) else $error("write into full store");
	property p_erase;
		@(posedge sys_clk) disable iff (!rst_n)
			fire[0] && s.pe[0].cfg.er && s.pe[0].cfg.a < EXT_SEL && !av_req.write
			&& s.pe[1].st != ST_WR |=> !s.fill[$past(s.pe[0].cfg.a[1:0])];
	endproperty
	a_erase: assert property (p_erase) else $error("read-erase left fill set");
	property p_active;
		@(posedge sys_clk) disable iff (!rst_n) fire[0] |=> s.pe[0].st == ST_RUN [*1];
	endproperty
	a_active: assert property (p_active) else $error("not active after consume");
	property p_done;
		@(posedge sys_clk) disable iff (!rst_n)
			s.done |-> s.pe[0].st == ST_IDLE && s.pe[1].st == ST_IDLE;
	endproperty
	a_done: assert property (p_done) else $error("done while element active");
	property p_size;
		@(posedge sys_clk) disable iff (!rst_n)
			s.pe[0].st == ST_WR && !s.fill[s.pe[0].cfg.o] && !av_req.write
			&& (s.pe[0].res[DW-1:0] >> s.size[s.pe[0].cfg.o]) != '0
			|=> s.sexc[$past(s.pe[0].cfg.o)] == SX_SIZE;
	endproperty
	a_size: assert property (p_size) else $error("size exception missing");
	property p_undef;
		@(posedge sys_clk) disable iff (!rst_n)
			fire[0] && s.pe[0].cfg.op inside {3'h5, 3'h6} |=> s.pe[0].exc == PX_UNDEF;
	endproperty
	a_undef: assert property (p_undef) else $error("undefined op not flagged");
	property p_conflict;
		@(posedge sys_clk) disable iff (!rst_n)
			fire[0] && fire[1] |-> !(s.pe[0].cfg.er && s.pe[1].cfg.er
			&& s.pe[0].cfg.a == s.pe[1].cfg.a && s.pe[0].cfg.a < EXT_SEL);
	endproperty
	a_conflict: assert property (p_conflict) else $error("double read-erase");
	property p_bus;
		@(posedge sys_clk) disable iff (!rst_n)
			(av_req.read || av_req.write) && av_rsp.waitrequest |=> !av_rsp.waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("waitrequest held too long");
endmodule

// file: rtl/dte_pkg.sv
// Constants, codes and carrier types of the dataflow token engine
package dte_pkg;
	localparam int NS = 4;
	localparam int NE = 2;
	localparam int DW = 8;
	localparam logic [2:0] EXT_SEL = 3'h4;
	// --------------------------------
	// Register byte offsets
	// --------------------------------
	localparam logic [4:0] A_STORE = 5'h00;
	localparam logic [4:0] A_PE    = 5'h04;
	localparam logic [4:0] A_HALT  = 5'h08;
	localparam logic [4:0] A_STAT  = 5'h0C;
	localparam logic [4:0] A_DATA  = 5'h10;
	// --------------------------------
	// Field positions
	// --------------------------------
	localparam int SC_DATA = 0;
	localparam int SC_IDX  = 8;
	localparam int SC_INIT = 10;
	localparam int SC_LOAD = 11;
	localparam int SC_SIZE = 12;
	localparam int PC_PE   = 0;
	localparam int PC_OP   = 1;
	localparam int PC_A    = 4;
	localparam int PC_B    = 7;
	localparam int PC_O    = 10;
	localparam int PC_ER   = 12;
	localparam int PC_EN   = 13;
	localparam int PC_T    = 16;
	localparam int ST_SEXC = 4;
	localparam int ST_ACT  = 12;
	localparam int ST_PEXC = 14;
	localparam int ST_DONE = 18;
	// --------------------------------
	// Codes and reset values
	// --------------------------------
	localparam logic [1:0] SX_NONE = 2'h0;
	localparam logic [1:0] SX_SIZE = 2'h1;
	localparam logic [1:0] SX_WR   = 2'h2;
	localparam logic [1:0] SX_ER   = 2'h3;
	localparam logic [1:0] PX_NONE = 2'h0;
	localparam logic [1:0] PX_FLOW = 2'h1;
	localparam logic [1:0] PX_OVF  = 2'h2;
	localparam logic [1:0] PX_UNDEF = 2'h3;
	localparam logic [2:0] OP_PASS = 3'h0;
	localparam logic [2:0] OP_ADD  = 3'h1;
	localparam logic [2:0] OP_SUB  = 3'h2;
	localparam logic [2:0] OP_AND  = 3'h3;
	localparam logic [2:0] OP_XOR  = 3'h4;
	localparam logic [2:0] OP_JUMP = 3'h7;
	localparam logic [3:0] SIZE_RST = 4'h8;
	localparam logic [DW-1:0] DATA_RST = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN  = 3'h2,
		ST_WR   = 3'h4
	} dte_pe_st_t;

	typedef struct packed {
		logic       en;
		logic [2:0] op;
		logic [2:0] a;
		logic [2:0] b;
		logic [1:0] o;
		logic       er;
		logic [3:0] t;
	} dte_pe_cfg_t;

	typedef struct packed {
		dte_pe_st_t  st;
		dte_pe_cfg_t cfg;
		logic [3:0]  cnt;
		logic [DW:0] res;
		logic [1:0]  exc;
	} dte_pe_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [31:0] writedata;
	} dte_av_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} dte_av_rsp_t;

	typedef struct packed {
		logic [NS-1:0]         fill;
		logic [NS-1:0][DW-1:0] data;
		logic [NS-1:0][3:0]    size;
		logic [NS-1:0][1:0]    sexc;
		dte_pe_t [NE-1:0]      pe;
		logic                  halt;
		logic                  done;
		logic [DW:0]           ext1;
		logic [DW:0]           ext2;
		dte_av_rsp_t           rsp;
	} dte_state_t;
endpackage

// file: testbench/dte_ext_src.sv
// Far-side model: external token store on the switch
module dte_ext_src (
	input  wire logic       sys_clk,
	input  wire logic       put,
	input  wire logic [7:0] val,
	output logic            ext_fill,
	output logic [7:0]      ext_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ext_fill = 1'b0;
		ext_data = 8'hA5;
	end
	// Data scrambled while the store is empty
	always @(posedge sys_clk) begin
		ext_fill <= put;
		ext_data <= put ? val : ~ext_data;
	end
endmodule

// file: testbench/dte_engine_tb.sv
// Self-checking bench of the dataflow token engine
module dte_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dte_pkg::*;
	logic        sys_clk;
	logic        rst_n;
	logic        put;
	logic        done;
	logic        ext_fill;
	logic [7:0]  val;
	logic [7:0]  ext_data;
	logic [31:0] q;
	dte_av_req_t av_req;
	dte_av_rsp_t av_rsp;
	int          miscompares;
	int          total_checks;
	logic [2:0]  t_op [10] = '{OP_PASS, OP_ADD, OP_SUB, OP_AND, OP_XOR, 3'h5, 3'h6,
		OP_JUMP, OP_ADD, OP_SUB};
	logic [7:0]  t_x [10] = '{8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C,
		8'hFF, 8'h01};
	logic [7:0]  t_y [10] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05,
		8'h01, 8'h02};
	logic [7:0]  t_r [10] = '{8'h0C, 8'h11, 8'h07, 8'h04, 8'h09, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};
	logic [1:0]  t_e [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h1, 2'h2, 2'h2};

	dte_engine DUT (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.av_req   (av_req),
		.av_rsp   (av_rsp),
		.ext_fill (ext_fill),
		.ext_data (ext_data),
		.done     (done)
	);
	dte_ext_src PEER (
		.sys_clk  (sys_clk),
		.put      (put),
		.val      (val),
		.ext_fill (ext_fill),
		.ext_data (ext_data)
	);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// --------------------------------
	// Helpers
	// --------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		av_req <= {!wr, wr, a, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (av_rsp.waitrequest !== 1'b0 && n < 50);
		if (av_rsp.waitrequest !== 1'b0)
			chk(32'h0, 32'h1, "no bus answer");
		q = av_rsp.readdata;
		av_req <= '0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, 32'h0);
		chk(q & m, e, "register read");
	endtask
	function automatic logic [31:0] st_w(logic [1:0] s, logic i, logic l, logic [3:0] z,
		logic [7:0] d);
		return {16'h0000, z, l, i, s, d};
	endfunction
	function automatic logic [31:0] pe_w(logic p, logic [2:0] op, logic [2:0] a,
		logic [2:0] b, logic [1:0] o, logic en);
		return {12'h000, 4'h0, 2'h0, en, 1'b1, o, b, a, op, p};
	endfunction
	task automatic prep(input logic [2:0] op, input logic [2:0] a, input logic [3:0] sz);
		wr(A_PE, pe_w(1'b1, OP_PASS, 3'h0, 3'h0, 2'h0, 1'b0));
		for (int i = 0; i < NS; i++)
			wr(A_STORE, st_w(2'(i), 1'b1, 1'b0, (i == 2) ? sz : 4'h8, 8'h00));
		wr(A_PE, pe_w(1'b0, op, a, 3'h1, 2'h2, 1'b1));
	endtask
	task automatic load(input logic [7:0] x, input logic [7:0] y);
		wr(A_STORE, st_w(2'h0, 1'b0, 1'b1, 4'h8, x));
		wr(A_STORE, st_w(2'h1, 1'b0, 1'b1, 4'h8, y));
	endtask
	task automatic settle();
		int n;
		n = 0;
		repeat (4) @(posedge sys_clk);
		while (done !== 1'b1 && n < 500) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 500)
			chk(32'h0, 32'h1, "never done");
	endtask

	initial begin
		repeat (40000) @(posedge sys_clk);
		miscompares++;
		test_done();
	end
	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		rst_n = 1'b0;
		av_req = '0;
		put = 1'b0;
		val = 8'h00;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(A_STAT, 32'h0004_0000, 32'h0007_FFFF);
		rd(A_DATA, 32'h0, 32'hFFFF_FFFF);
		rd(5'h14, 32'h0, 32'hFFFF_FFFF);
		$display("test reset done");
		wr(A_STORE, st_w(2'h0, 1'b1, 1'b1, 4'h8, 8'h05));
		wr(A_STORE, st_w(2'h1, 1'b1, 1'b1, 4'h8, 8'h03));
		wr(A_STORE, st_w(2'h0, 1'b0, 1'b1, 4'h8, 8'h77));
		rd(A_STAT, 32'h0004_0023, 32'h0007_FFFF);
		rd(A_DATA, 32'h0000_0305, 32'h0000_FFFF);
		$display("test store load done");
		for (int i = 0; i < 10; i++) begin
			prep(t_op[i], 3'h0, 4'h8);
			load(t_x[i], t_y[i]);
			settle();
			rd(A_STAT, {13'h0, 1'b1, 2'h0, t_e[i], 11'h0, t_e[i] == 2'h0, 2'h0},
				32'h0004_C004);
			if (t_e[i] == 2'h0)
				rd(A_DATA, {8'h00, t_r[i], 16'h0000}, 32'h00FF_0000);
		end
		$display("test opcodes done");
		prep(OP_ADD, 3'h0, 4'h8);
		wr(A_STORE, st_w(2'h2, 1'b0, 1'b1, 4'h8, 8'h11));
		wr(A_PE, pe_w(1'b1, OP_PASS, 3'h2, 3'h0, 2'h3, 1'b1));
		load(8'h05, 8'h03);
		repeat (40) @(posedge sys_clk);
		rd(A_STAT, 32'h0000_2008, 32'h0007_FFFF);
		rd(A_DATA, 32'h1100_0000, 32'hFF00_0000);
		wr(A_STORE, st_w(2'h3, 1'b1, 1'b0, 4'h8, 8'h00));
		settle();
		rd(A_DATA, 32'h0800_0000, 32'hFF00_0000);
		rd(A_STAT, 32'h0004_0008, 32'h0007_FFFF);
		$display("test stall done");
		prep(OP_ADD, 3'h0, 4'h4);
		load(8'h0C, 8'h05);
		settle();
		rd(A_STAT, 32'h0004_0100, 32'h0004_0304);
		$display("test size done");
		prep(OP_PASS, 3'h0, 4'h8);
		wr(A_PE, pe_w(1'b1, OP_PASS, 3'h0, 3'h0, 2'h3, 1'b1));
		load(8'h3C, 8'h01);
		settle();
		rd(A_STAT, 32'h0004_0036, 32'h0007_FFFF);
		rd(A_DATA, 32'h003C_0000, 32'h00FF_0000);
		wr(A_PE, pe_w(1'b1, OP_PASS, 3'h0, 3'h0, 2'h0, 1'b0));
		$display("test conflict done");
		prep(OP_ADD, 3'h0, 4'h8);
		wr(A_HALT, 32'h1);
		load(8'h0C, 8'h05);
		repeat (10) @(posedge sys_clk);
		rd(A_STAT, 32'h0004_0003, 32'h0007_FFFF);
		rd(A_HALT, 32'h1, 32'h1);
		wr(A_HALT, 32'h0);
		settle();
		rd(A_DATA, 32'h0011_0000, 32'h00FF_0000);
		$display("test halt done");
		put <= 1'b1;
		val <= 8'h5A;
		prep(OP_PASS, EXT_SEL, 4'h8);
		repeat (30) @(posedge sys_clk);
		rd(A_DATA, 32'h005A_0000, 32'h00FF_0000);
		rd(A_STAT, 32'h0000_0004, 32'h0000_0004);
		wr(A_PE, pe_w(1'b0, OP_PASS, 3'h0, 3'h0, 2'h0, 1'b0));
		put <= 1'b0;
		$display("test external done");
		test_done();
	end
endmodule
